// file: logic/acs_pkg.sv
// shared constants, types and states of the converter control block
package acs_pkg;
	// system clock rate
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 20;
	// internal oscillator rates for the two notch settings
	localparam int unsigned FOSC_60_HZ = 153_600;
	localparam int unsigned FOSC_50_HZ = 128_000;
	// oscillator ticks per first-null period
	localparam int unsigned NOTCH_DIV = 2560;
	// clock cycles per oscillator tick, rounded down
	localparam int unsigned DIV_60 = CLK_HZ / FOSC_60_HZ;
	localparam int unsigned DIV_50 = CLK_HZ / FOSC_50_HZ;
	// power-on reset time and its cycle count, rounded up
	localparam int unsigned POR_TIME_NS = 500_000;
	localparam int unsigned POR_CYC = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
	// slowest detectable external clock and its timeout in cycles
	localparam int unsigned EXT_MIN_HZ = 2560;
	localparam int unsigned EXT_TIMEOUT_CYC = CLK_HZ / EXT_MIN_HZ;
	// half period of the internally made serial clock, in cycles
	localparam int unsigned SCK_HALF_CYC = 25;
	// conversion length and calibration slice, in oscillator ticks
	localparam int unsigned CONV_TICKS = NOTCH_DIV;
	localparam int unsigned CAL_TICKS = 256;
	// frame layout
	localparam int unsigned FRAME_BITS = 32;
	localparam int unsigned RESULT_BITS = 24;
	localparam int unsigned SUB_BITS = 5;
	localparam int unsigned EOC_POS = 31;
	localparam int unsigned FILL_POS = 30;
	localparam int unsigned SIGN_POS = 29;
	localparam int unsigned MSB_POS = 28;
	localparam int unsigned RES_LSB = 5;
	// fifo depth
	localparam int unsigned FIFO_DEPTH = 8;
	// one finished conversion from the filter
	typedef struct packed {
		logic over;
		logic under;
		logic sign;
		logic [RESULT_BITS-1:0] result;
		logic [SUB_BITS-1:0] sub;
	} acs_word_s;
	// converter cycle states
	typedef enum logic [1:0] {
		ACS_CONV,
		ACS_SLEEP,
		ACS_OUT
	} acs_state_e;
endpackage : acs_pkg

// file: logic/acs_top.sv
// conversion cycle control, result fifo and serial frame output
// Functional notes
// - notch high: internal oscillator, 50Hz null or dual
// - notch low: internal oscillator, 60Hz or dual
// - external notch clock drives conversion ticks
// - cycle conversion, sleep, output; start converting
// - after conversion sleep while select high
// - sleep holds result in shift register
// - select low shifts current result, no latency
// - data changes falling edge, host samples rising
// - output ends at 32 bits or select high
// - modes chosen by pin timing only
// - calibration inside every conversion, timing unchanged
// - low supply holds internal reset
// - power-on reset clears registers, then convert
// - frame: 3 status, 24 result, 5 sub
// - bits three and four flag range errors
// - first bit is active-low conversion done
// - done flag shown while select low
// - second bit filler, always low
// - third bit is input polarity
// - select high: output off, clock ignored
// - overrange both high, underrange both low
// - 32nd falling edge drives output high
// - select rise during output aborts, converts
`timescale 1ns/1ps
// word fifo between filter and frame logic
module acs_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	import acs_pkg::*;
	localparam int unsigned AW = $clog2(DEPTH);
	// whole fifo state
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} acs_fifo_s;
	acs_fifo_s r, n;
	logic [AW:0] fill;
	logic push;
	logic pop;

	// fill level and handshakes
	always_comb begin
		fill = r.wr - r.rd;
		in_ready_o = (fill != (AW+1)'(DEPTH));
		out_valid_o = (fill != '0);
		out_data_o = r.mem[r.rd[AW-1:0]];
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		n = r;
		// write side
		if (push) begin
			n.mem[r.wr[AW-1:0]] = in_data_i;
			n.wr = r.wr + 1'b1;
		end
		// read side
		if (pop) begin
			n.rd = r.rd + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : acs_fifo

// converter control and serial interface
module acs_top #(
	parameter int unsigned POR_CYCLES = acs_pkg::POR_CYC,
	parameter int unsigned EXT_TIMEOUT = acs_pkg::EXT_TIMEOUT_CYC,
	parameter int unsigned CONV_LEN = acs_pkg::CONV_TICKS,
	parameter int unsigned CAL_LEN = acs_pkg::CAL_TICKS,
	parameter int unsigned SCK_HALF = acs_pkg::SCK_HALF_CYC,
	parameter int unsigned DIV_DUAL = acs_pkg::DIV_60,
	parameter bit DUAL_NOTCH = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic supply_low_i,
	input wire logic notch_select_input_i,
	input wire logic cs_b_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic word_valid_i,
	input wire acs_pkg::acs_word_s word_i,
	output logic word_ready_o,
	output logic sys_tick_o,
	output logic notch_ext_o,
	output logic notch_50_o,
	output logic cal_o,
	output logic sleep_o,
	output logic por_o
);
	import acs_pkg::*;
	localparam int unsigned WW = $bits(acs_word_s);
	// whole control state
	typedef struct packed {
		logic [2:0] cs_sy;
		logic [2:0] sck_sy;
		logic [2:0] f0_sy;
		logic [1:0] bo_sy;
		acs_state_e st;
		logic por_busy;
		logic [19:0] por_cnt;
		logic ext_mode;
		logic [19:0] ext_cnt;
		logic [9:0] div_cnt;
		logic [15:0] conv_cnt;
		logic [FRAME_BITS-1:0] shreg;
		logic [5:0] bit_cnt;
		logic int_sck;
		logic sck_q;
		logic [9:0] sck_div;
		logic sdo;
	} acs_ctl_s;
	acs_ctl_s r, n;
	// fifo read side
	logic f_valid;
	logic f_ready;
	logic [WW-1:0] f_data;
	// decoded pin events
	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sck_fall_ext;
	logic f0_rise;
	logic tick;
	logic conv_done;
	logic [9:0] div_sel;
	logic shift;

	// pack a finished word into a frame
	function automatic logic [FRAME_BITS-1:0] build_frame(input acs_word_s w);
		logic [FRAME_BITS-1:0] f;
		f = '0;
		f[EOC_POS] = 1'b0;
		f[FILL_POS] = 1'b0;
		f[SIGN_POS] = w.sign;
		f[MSB_POS -: RESULT_BITS] = w.result;
		f[SUB_BITS-1:0] = w.sub;
		// range codes on third and fourth bits
		if (w.over) begin
			f[SIGN_POS] = 1'b1;
			f[MSB_POS] = 1'b1;
		end else if (w.under) begin
			f[SIGN_POS] = 1'b0;
			f[MSB_POS] = 1'b0;
		end
		return f;
	endfunction : build_frame

	// results from the filter wait here
	acs_fifo #(
		.W(WW),
		.DEPTH(FIFO_DEPTH)
	) acs_fifo_inst (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(word_valid_i),
		.in_data_i(word_i),
		.in_ready_o(word_ready_o),
		.out_valid_o(f_valid),
		.out_data_o(f_data),
		.out_ready_i(f_ready)
	);

	// pin decode, all from second and third sync stages
	always_comb begin
		cs_low = ~r.cs_sy[1];
		cs_fall = r.cs_sy[2] & ~r.cs_sy[1];
		cs_rise = ~r.cs_sy[2] & r.cs_sy[1];
		sck_fall_ext = r.sck_sy[2] & ~r.sck_sy[1];
		f0_rise = ~r.f0_sy[2] & r.f0_sy[1];
		// oscillator divisor by notch level and variant
		if (DUAL_NOTCH) begin
			div_sel = 10'(DIV_DUAL);
		end else if (r.f0_sy[1]) begin
			div_sel = 10'(DIV_50);
		end else begin
			div_sel = 10'(DIV_60);
		end
		// tick from outside clock or internal divider
		tick = r.ext_mode ? f0_rise : (r.div_cnt == div_sel - 10'h001);
		conv_done = (r.conv_cnt >= 16'(CONV_LEN - 1));
		// shift edge: own falling clock or host falling clock
		if (r.int_sck) begin
			shift = (r.st == ACS_OUT) & r.sck_q & (r.sck_div == 10'(SCK_HALF - 1));
		end else begin
			shift = (r.st == ACS_OUT) & sck_fall_ext;
		end
		f_ready = (r.st == ACS_CONV) & conv_done & tick & ~r.por_busy;
	end

	// next state
	always_comb begin
		n = r;
		// two-stage synchronisers, plus edge stage on all but supply
		n.cs_sy = {r.cs_sy[1:0], cs_b_i};
		n.sck_sy = {r.sck_sy[1:0], sck_i};
		n.f0_sy = {r.f0_sy[1:0], notch_select_input_i};
		n.bo_sy = {r.bo_sy[0], supply_low_i};
		// external clock detect by edge spacing
		if (f0_rise) begin
			n.ext_cnt = '0;
			if (r.ext_cnt < 20'(EXT_TIMEOUT)) begin
				n.ext_mode = 1'b1;
			end
		end else if (r.ext_cnt >= 20'(EXT_TIMEOUT)) begin
			n.ext_mode = 1'b0;
		end else begin
			n.ext_cnt = r.ext_cnt + 20'h00001;
		end
		// internal oscillator divider
		if (r.ext_mode || r.div_cnt >= div_sel - 10'h001) begin
			n.div_cnt = '0;
		end else begin
			n.div_cnt = r.div_cnt + 10'h001;
		end
		// serial clock mode sampled on select fall
		if (cs_fall) begin
			n.int_sck = r.sck_sy[1];
		end
		unique case (r.st)
			// conversion with calibration slice at its end
			ACS_CONV: begin
				n.bit_cnt = '0;
				n.sck_q = 1'b0;
				n.sck_div = '0;
				if (tick && !conv_done) begin
					n.conv_cnt = r.conv_cnt + 16'h0001;
				end
				if (f_ready && f_valid) begin
					n.shreg = build_frame(acs_word_s'(f_data));
					n.st = ACS_SLEEP;
				end
			end
			// hold result until select goes low
			ACS_SLEEP: begin
				if (cs_low) begin
					n.st = ACS_OUT;
				end
			end
			// shift frame out
			ACS_OUT: begin
				// own serial clock generator
				if (r.int_sck) begin
					if (r.sck_div == 10'(SCK_HALF - 1)) begin
						n.sck_div = '0;
						n.sck_q = ~r.sck_q;
					end else begin
						n.sck_div = r.sck_div + 10'h001;
					end
				end
				if (shift) begin
					n.shreg = {r.shreg[FRAME_BITS-2:0], 1'b1};
					n.bit_cnt = r.bit_cnt + 6'h01;
				end
				if (cs_rise) begin
					n.st = ACS_CONV;
					n.conv_cnt = '0;
				end else if (shift && r.bit_cnt == 6'(FRAME_BITS - 1)) begin
					n.st = ACS_CONV;
					n.conv_cnt = '0;
				end
			end
		endcase
		// supply drop or power-on reset holds the cycle state and shifter cleared
		if (r.bo_sy[1]) begin
			n.por_busy = 1'b1;
			n.por_cnt = '0;
		end else if (r.por_busy) begin
			if (r.por_cnt >= 20'(POR_CYCLES - 1)) begin
				n.por_busy = 1'b0;
				n.int_sck = r.sck_sy[1];
			end else begin
				n.por_cnt = r.por_cnt + 20'h00001;
			end
		end
		if (r.bo_sy[1] || r.por_busy) begin
			n.st = ACS_CONV;
			n.conv_cnt = '0;
			n.shreg = '0;
			n.bit_cnt = '0;
			n.sck_q = 1'b0;
			n.sck_div = '0;
		end
		// registered output level: frame bit or done flag
		n.sdo = (n.st == ACS_OUT) ? n.shreg[EOC_POS] : (n.st == ACS_CONV);
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
			r.cs_sy <= 3'h7;
			r.sck_sy <= 3'h7;
			r.st <= ACS_CONV;
			r.por_busy <= 1'b1;
			r.sdo <= 1'b1;
			r.ext_cnt <= 20'(EXT_TIMEOUT); // no earlier edge, first rise is no clock
		end else begin
			r <= n;
		end
	end

	// pin and status outputs
	always_comb begin
		sdo_o = r.sdo;
		sdo_oe_o = cs_low;
		sck_o = r.sck_q;
		sck_oe_o = r.int_sck & cs_low & (r.st == ACS_OUT);
		sys_tick_o = tick;
		notch_ext_o = r.ext_mode;
		notch_50_o = ~r.ext_mode & r.f0_sy[1] & ~DUAL_NOTCH;
		cal_o = (r.st == ACS_CONV) & ~r.por_busy & (r.conv_cnt >= 16'(CONV_LEN - CAL_LEN));
		sleep_o = (r.st == ACS_SLEEP) & ~cs_low;
		por_o = r.por_busy;
	end
endmodule : acs_top

// file: testbench/acs_top_props.sv
// port checker for the converter control block
`timescale 1ns/1ps
module acs_top_props (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_b_i,
	input wire logic notch_select_input_i,
	input wire logic sck_oe_o,
	input wire logic sdo_o,
	input wire logic sdo_oe_o,
	input wire logic sys_tick_o,
	input wire logic notch_ext_o,
	input wire logic notch_50_o,
	input wire logic cal_o,
	input wire logic sleep_o,
	input wire logic por_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// power-on wait after release
	sequence por_run;
		por_o [*8];
	endsequence
	// select held low past the sync stages
	sequence cs_held_low;
		$fell(cs_b_i) ##1 !cs_b_i [*4];
	endsequence
	por_len_a: assert property ($rose(rst_b_i) |-> por_run)
		else $error("power-on wait too short");
	por_sdo_a: assert property (por_o |-> sdo_o)
		else $error("data low during power-on wait");
	sdo_off_a: assert property (cs_b_i [*4] |-> !sdo_oe_o)
		else $error("data driven while deselected");
	sdo_on_a: assert property (cs_held_low |-> sdo_oe_o)
		else $error("data not driven while selected");
	sleep_sck_a: assert property (sleep_o |-> !sck_oe_o && !sdo_o)
		else $error("clock driven or done flag high in sleep");
	cal_busy_a: assert property (cal_o && sdo_oe_o |-> sdo_o)
		else $error("done flag low during calibration");
	tick_one_a: assert property (sys_tick_o |=> !sys_tick_o)
		else $error("tick longer than one cycle");
	notch_sel_a: assert property ((!notch_ext_o && $stable(notch_select_input_i)) [*8] |->
		notch_50_o == notch_select_input_i)
		else $error("notch setting wrong");
	sck_drv_a: assert property (cs_b_i [*4] |-> !sck_oe_o)
		else $error("clock driven while deselected");
endmodule : acs_top_props

bind acs_top acs_top_props acs_top_props_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.cs_b_i(cs_b_i), .notch_select_input_i(notch_select_input_i), .sck_oe_o(sck_oe_o),
	.sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sys_tick_o(sys_tick_o), .notch_ext_o(notch_ext_o),
	.notch_50_o(notch_50_o), .cal_o(cal_o), .sleep_o(sleep_o), .por_o(por_o));

// file: testbench/acs_host.sv
// host model reading frames on either serial clock
`timescale 1ns/1ps
module acs_host (
	input wire logic clk_i,
	input wire logic sdo_i,
	input wire logic sck_i,
	output logic cs_b_o,
	output logic sck_o
);
	localparam int HALF = 8; // cycles per serial clock half
	initial begin
		cs_b_o = 1'b1;
		sck_o = 1'b0;
	end
	// select, wait for done flag, clock n bits, release
	task automatic read_frame(input int n, output logic [31:0] f, output logic busy,
		output logic tail);
		int w;
		f = '0;
		w = 0;
		@(posedge clk_i);
		cs_b_o <= 1'b0; // clock low at select
		repeat (HALF) @(posedge clk_i);
		busy = sdo_i;
		while (sdo_i !== 1'b0 && w < 20000) begin
			@(posedge clk_i);
			w++;
		end
		if (w >= 20000) busy = 1'bx; // wait ran out, fails the check
		for (int i = 0; i < n; i++) begin
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'b1;
			f = {f[30:0], sdo_i}; // taken at rising clock
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		repeat (HALF) @(posedge clk_i);
		tail = sdo_i;
		cs_b_o <= 1'b1;
	endtask : read_frame
	// select with clock high, take 32 bits on the device's own clock
	task automatic read_int(output logic [31:0] f);
		int w;
		int k;
		logic p;
		f = '0;
		w = 0;
		k = 0;
		p = 1'b1;
		@(posedge clk_i);
		sck_o <= 1'b1; // clock high at select picks own clock
		cs_b_o <= 1'b0;
		while (k < 32 && w < 20000) begin
			@(posedge clk_i);
			w++;
			if (sck_i && !p) begin
				f = {f[30:0], sdo_i}; // taken at rising clock
				k++;
			end
			p = sck_i;
		end
		if (k < 32) f = 'x; // ran out of time, fails the check
		repeat (HALF) @(posedge clk_i);
		sck_o <= 1'b0;
		cs_b_o <= 1'b1;
	endtask : read_int
endmodule : acs_host

// file: testbench/acs_top_bench.sv
// bench for the converter control block
`timescale 1ns/1ps
module acs_top_bench;
	import acs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic supply_low_i = 1'b0;
	logic notch_select_input_i = 1'b0;
	logic word_valid_i = 1'b0;
	acs_word_s word_i = '0;
	logic cs_b, host_sck, sck_o, sck_oe_o, sdo_o, sdo_oe_o, word_ready_o, sys_tick_o;
	logic notch_ext_o, notch_50_o, cal_o, sleep_o, por_o, busy, tail;
	logic [31:0] f;
	int num_errors = 0;
	int compares = 0;
	acs_word_s words [8];
	wire sdo_w = sdo_oe_o ? sdo_o : 1'bz; // released data line floats
	wire sck_w = sck_oe_o ? sck_o : host_sck; // shared clock pin
	always #10 clk_i = ~clk_i; // 50 MHz
	acs_top #(.POR_CYCLES(20), .EXT_TIMEOUT(50), .CONV_LEN(8), .CAL_LEN(2)) acs_top_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .supply_low_i(supply_low_i),
		.notch_select_input_i(notch_select_input_i), .cs_b_i(cs_b), .sck_i(sck_w),
		.sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
		.word_valid_i(word_valid_i), .word_i(word_i), .word_ready_o(word_ready_o),
		.sys_tick_o(sys_tick_o), .notch_ext_o(notch_ext_o), .notch_50_o(notch_50_o),
		.cal_o(cal_o), .sleep_o(sleep_o), .por_o(por_o));
	acs_host acs_host_inst (.clk_i(clk_i), .sdo_i(sdo_w), .sck_i(sck_w), .cs_b_o(cs_b),
		.sck_o(host_sck));
	// count and report one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// expected frame of one filter word
	function automatic logic [31:0] frame(input acs_word_s w);
		logic [31:0] r;
		r = {2'b00, w.sign, w.result, w.sub};
		if (w.over) r[29:28] = 2'b11;
		else if (w.under) r[29:28] = 2'b00;
		return r;
	endfunction : frame
	// counts, verdict, end of run
	task automatic print_verdict();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// hang guard
	initial begin
		repeat (60000) @(posedge clk_i);
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		for (int i = 0; i < 8; i++) begin
			words[i] = {(i == 2), (i == 3), i[0], 24'(24'ha5c3f0 ^ (24'h111111 * i)), 5'(i * 3 + 1)};
		end
		repeat (20) @(posedge clk_i);
		chk({por_o, sdo_oe_o}, 2'b10);
		rst_b_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(por_o, 0);
		$display("test reset done");
		// fill fifo, ninth word refused
		for (int i = 0; i < 8; i++) begin
			word_valid_i <= 1'b1;
			word_i <= words[i];
			@(posedge clk_i);
		end
		word_i <= ~words[0];
		repeat (3) @(posedge clk_i);
		chk(word_ready_o, 0);
		word_valid_i <= 1'b0;
		$display("test fill done");
		// notch levels and external clock
		notch_select_input_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		chk(notch_50_o, 1);
		for (int i = 0; i < 60; i++) begin
			repeat (3) @(posedge clk_i);
			notch_select_input_i <= ~notch_select_input_i;
		end
		repeat (3) @(posedge clk_i);
		chk(notch_ext_o, 1);
		notch_select_input_i <= 1'b0;
		repeat (150) @(posedge clk_i);
		chk({notch_ext_o, notch_50_o}, 0);
		chk(sleep_o, 1);
		$display("test notch done");
		// frames in order, fifth one aborted
		for (int i = 0; i < 8; i++) begin
			acs_host_inst.read_frame(i == 4 ? 5 : 32, f, busy, tail);
			chk(busy, i == 0 ? 0 : 1);
			if (i == 4) chk(32'(f[4:0]), frame(words[i]) >> 27);
			else chk(f, frame(words[i]));
			if (i != 4) chk(tail, 1);
		end
		repeat (3000) @(posedge clk_i);
		chk({sleep_o, word_ready_o}, 2'b01);
		chk(cal_o, 1);
		$display("test frames done");
		// one more word, read on the device's own clock
		word_valid_i <= 1'b1;
		word_i <= ~words[1];
		@(posedge clk_i);
		word_valid_i <= 1'b0;
		acs_host_inst.read_int(f);
		chk(f, frame(~words[1]));
		$display("test own clock done");
		// low supply restarts power-on wait
		supply_low_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk(por_o, 1);
		supply_low_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(por_o, 0);
		chk(cal_o, 0);
		$display("test supply done");
		print_verdict();
	end
endmodule : acs_top_bench
